// File: core/bio_decode.sv
/*
  Host I/O address decoder and interrupt router for a quadrature counter card.
  Assumes host bus pins arrive asynchronous and are synchronised here; jumpers
  are static pins; the card interrupt source runs on i_ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module bio_decode (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire bio_pkg::bio_isa_s i_isa,
  input wire logic [bio_pkg::BASE_W-1:0] i_base_jmp_on,
  input wire logic [bio_pkg::IRQ_W-1:0] i_irq_jmp_on,
  input wire logic i_card_irq,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output bio_pkg::bio_acc_s o_acc,
  output logic [bio_pkg::IRQ_W-1:0] o_irq
);

  localparam int unsigned SYNC_W = $bits(bio_pkg::bio_isa_s) + bio_pkg::BASE_W
                                   + bio_pkg::IRQ_W;

  typedef struct packed {
    logic [1:0] ctrl;
    logic [bio_pkg::HITS_W-1:0] hits;
    logic [bio_pkg::OFF_W-1:0] last_off;
    logic act;
    bio_pkg::bio_acc_s acc;
    logic [bio_pkg::IRQ_W-1:0] irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bio_state_s;

  bio_state_s st_q;
  bio_state_s st_d;

  bio_pkg::bio_isa_s isa_s;
  logic [bio_pkg::BASE_W-1:0] jmp_s;
  logic [bio_pkg::IRQ_W-1:0] irq_jmp_s;

  bio_sync #(
    .W(SYNC_W)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_d({i_isa, i_base_jmp_on, i_irq_jmp_on}),
    .o_q({isa_s, jmp_s, irq_jmp_s})
  );

  // Window hit: upper lines equal base, base legal, no DMA cycle
  function automatic logic base_hit(input bio_pkg::bio_isa_s a,
                                    input logic [bio_pkg::BASE_W-1:0] base);
    base_hit = (a.sa[9:5] == base)
               && (base >= bio_pkg::BASE_MIN)
               && !a.aen;
  endfunction

  // One level only: lowest legal jumper wins if several are fitted
  function automatic logic [bio_pkg::IRQ_W-1:0] irq_pick(
      input logic [bio_pkg::IRQ_W-1:0] jmp);
    logic [bio_pkg::IRQ_W-1:0] legal;
    legal = jmp & bio_pkg::IRQ_LEGAL;
    irq_pick = legal & (~legal + 16'h0001);
  endfunction

  function automatic logic [3:0] lvl_of(input logic [bio_pkg::IRQ_W-1:0] oh);
    lvl_of = 4'h0;
    for (int i = 0; i < bio_pkg::IRQ_W; i++) begin
      if (oh[i]) begin
        lvl_of = 4'(i);
      end
    end
  endfunction

  logic [bio_pkg::BASE_W-1:0] base_cfg;
  logic [bio_pkg::IRQ_W-1:0] irq_sel;
  logic hit;
  logic strobe;
  logic apb_setup;
  logic apb_wr;
  logic mapped;

  always_comb begin
    base_cfg = ~jmp_s;
    irq_sel = irq_pick(irq_jmp_s);
    strobe = !isa_s.ior_n || !isa_s.iow_n;
    hit = base_hit(isa_s, base_cfg) && st_q.ctrl[bio_pkg::CTRL_DEC_EN] && strobe;
    apb_setup = i_psel && !i_penable;
    apb_wr = i_psel && i_penable && i_pwrite && st_q.pready;
    mapped = (i_paddr == bio_pkg::REG_CTRL) || (i_paddr == bio_pkg::REG_STAT)
             || (i_paddr == bio_pkg::REG_HITS);

    st_d = st_q;

    // Host access decode; pulses mark the strobe's leading edge only
    st_d.act = hit;
    st_d.acc.sel = hit;
    st_d.acc.rd = hit && !st_q.act && !isa_s.ior_n;
    st_d.acc.wr = hit && !st_q.act && !isa_s.iow_n;
    if (hit) begin
      st_d.acc.off = isa_s.sa[4:0];
      st_d.acc.chan = isa_s.sa[3:1];
      st_d.acc.is_ctrl = isa_s.sa[0] && !isa_s.sa[4];
    end
    if (hit && !st_q.act) begin
      st_d.hits = st_q.hits + 16'h0001;
      st_d.last_off = isa_s.sa[4:0];
    end

    // Card interrupt reaches only the jumpered level
    st_d.irq = (i_card_irq && st_q.ctrl[bio_pkg::CTRL_IRQ_EN]) ? irq_sel : 16'h0000;

    // APB: data prepared in setup, answered with no wait states
    st_d.pready = apb_setup;
    st_d.pslverr = apb_setup && !mapped;
    st_d.prdata = 32'h0000_0000;
    if (apb_setup && !i_pwrite) begin
      case (i_paddr)
        bio_pkg::REG_CTRL: st_d.prdata[1:0] = st_q.ctrl;
        bio_pkg::REG_STAT: begin
          st_d.prdata[bio_pkg::STAT_BASE_LSB +: bio_pkg::BASE_W] = base_cfg;
          st_d.prdata[bio_pkg::STAT_VALID] = base_cfg >= bio_pkg::BASE_MIN;
          st_d.prdata[bio_pkg::STAT_SEL] = st_q.acc.sel;
          st_d.prdata[bio_pkg::STAT_OFF_LSB +: bio_pkg::OFF_W] = st_q.last_off;
          st_d.prdata[bio_pkg::STAT_LVL_LSB +: 4] = lvl_of(irq_sel);
        end
        bio_pkg::REG_HITS: st_d.prdata[bio_pkg::HITS_W-1:0] = st_q.hits;
        default: st_d.prdata = 32'h0000_0000;
      endcase
    end
    if (apb_wr && (i_paddr == bio_pkg::REG_CTRL)) begin
      st_d.ctrl = i_pwdata[1:0];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= '0;
      st_q.ctrl <= bio_pkg::CTRL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_prdata = st_q.prdata;
  assign o_pready = st_q.pready;
  assign o_pslverr = st_q.pslverr;
  assign o_acc = st_q.acc;
  assign o_irq = st_q.irq;

endmodule
`default_nettype wire

// File: core/bio_pkg.sv
/*
  Constants, carrier structs and register map for the board I/O address decoder.
  Assumes a single 25 MHz clock and an APB master for its own registers.
*/
package bio_pkg;

  localparam int unsigned ADDR_W = 10;
  localparam int unsigned OFF_W = 5;
  localparam int unsigned BASE_W = 5;
  localparam int unsigned IRQ_W = 16;
  localparam int unsigned HITS_W = 16;

  // Lowest legal base field: 100h >> 5
  localparam logic [BASE_W-1:0] BASE_MIN = 5'h08;
  // Levels 2-7, 10-12 and 15
  localparam logic [IRQ_W-1:0] IRQ_LEGAL = 16'h9CFC;

  // APB register byte addresses
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam logic [11:0] REG_HITS = 12'h008;

  // Control register fields and reset
  localparam int unsigned CTRL_DEC_EN = 0;
  localparam int unsigned CTRL_IRQ_EN = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;

  // Status register field positions
  localparam int unsigned STAT_BASE_LSB = 0;
  localparam int unsigned STAT_VALID = 5;
  localparam int unsigned STAT_SEL = 6;
  localparam int unsigned STAT_OFF_LSB = 7;
  localparam int unsigned STAT_LVL_LSB = 12;

  typedef struct packed {
    logic [ADDR_W-1:0] sa;
    logic aen;
    logic ior_n;
    logic iow_n;
  } bio_isa_s;

  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic [OFF_W-1:0] off;
    logic [2:0] chan;
    logic is_ctrl;
  } bio_acc_s;

endpackage

// File: core/bio_sync.sv
/*
  Two-flop synchroniser for a bundle of pin levels.
  Assumes each bit is an independent slow level; no bus coherency is given.
*/
`timescale 1ns/1ps
`default_nettype none
module bio_sync #(
  parameter int unsigned W = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bio_sync_s;

  bio_sync_s st_q;
  bio_sync_s st_d;

  always_comb begin
    st_d.s1 = i_d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_q = st_q.s2;

endmodule
`default_nettype wire

// File: verification/bio_host.sv
/* Host processor model driving the card's bus pins.
   Assumes one caller at a time on the bench clock. */
`timescale 1ns/1ps
`default_nettype none
module bio_host (
  input wire logic i_ref_clk,
  output var bio_pkg::bio_isa_s o_isa
);
  initial o_isa = '{sa: 10'h3FF, aen: 1'b0, ior_n: 1'b1, iow_n: 1'b1};
  // Released lines show the inverse address so stale values never match
  task automatic io_cycle(input logic [9:0] a, input logic w, input logic dma);
    @(posedge i_ref_clk);
    o_isa <= '{sa: a, aen: dma, ior_n: w, iow_n: !w};
    repeat (4) @(posedge i_ref_clk);
    o_isa <= '{sa: ~a, aen: 1'b0, ior_n: 1'b1, iow_n: 1'b1};
    repeat (5) @(posedge i_ref_clk);
  endtask
endmodule
`default_nettype wire

// File: verification/bio_decode_properties.sv
/* Checks on decoder select, offset and interrupt outputs.
   Assumes static jumpers; bound to every decoder instance. */
`timescale 1ns/1ps
`default_nettype none
module bio_decode_properties (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire bio_pkg::bio_isa_s i_isa,
  input wire logic [bio_pkg::BASE_W-1:0] i_base_jmp_on,
  input wire logic i_card_irq,
  input wire bio_pkg::bio_acc_s o_acc,
  input wire logic [bio_pkg::IRQ_W-1:0] o_irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence hit_s;
    $rose(o_acc.sel) ##0 (o_acc.rd || o_acc.wr);
  endsequence
  chk_addr_match: assert property (
    o_acc.sel |-> $past(i_isa.sa[9:5], 3) == ~i_base_jmp_on) else $error("bad select");
  chk_no_dma: assert property (
    o_acc.sel |-> !$past(i_isa.aen, 3)) else $error("dma select");
  chk_base_floor: assert property (
    o_acc.sel |-> ~i_base_jmp_on >= bio_pkg::BASE_MIN) else $error("low base");
  chk_low_offset: assert property (
    hit_s |-> o_acc.off == $past(i_isa.sa[4:0], 3)) else $error("bad offset");
  chk_odd_ctrl: assert property (
    hit_s |-> o_acc.is_ctrl == (o_acc.off[0] && !o_acc.off[4])) else $error("bad port");
  chk_chan_pair: assert property (
    hit_s |-> o_acc.chan == $past(i_isa.sa[3:1], 3)) else $error("bad channel");
  chk_pulse_once: assert property (
    hit_s |=> !(o_acc.rd || o_acc.wr)) else $error("double pulse");
  chk_irq_legal: assert property (
    o_irq != 0 |-> $onehot(o_irq) && (o_irq & ~bio_pkg::IRQ_LEGAL) == 0) else $error("irq");
  chk_irq_cause: assert property (
    o_irq != 0 |-> $past(i_card_irq)) else $error("irq cause");
endmodule
bind bio_decode bio_decode_properties u_props (.*);
`default_nettype wire

// File: verification/board_io_address_decode_tb.sv
/* Bench for bio_decode: register reads, host cycles, interrupt routing.
   Assumes bio_host drives the bus pins. */
`timescale 1ns/1ps
`default_nettype none
module board_io_address_decode_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] bon = 5'h07;
  logic [15:0] ion = 16'h0421;
  logic cirq = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd, rdat, nhit = 32'h0;
  logic prdy, perr, rerr;
  logic [15:0] irq;
  logic [4:0] loff;
  bio_pkg::bio_isa_s isa;
  bio_pkg::bio_acc_s acc;
  int fail_count = 0;
  int checked = 0;
  always #20 clk = ~clk;
  bio_host u_host (.i_ref_clk(clk), .o_isa(isa));
  bio_decode DUT (.i_ref_clk(clk), .i_rst(rst), .i_isa(isa), .i_base_jmp_on(bon),
    .i_irq_jmp_on(ion), .i_card_irq(cirq), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
    .o_pslverr(perr), .o_acc(acc), .o_irq(irq));
  always @(posedge clk) begin
    if (acc.rd === 1'b1 || acc.wr === 1'b1) begin
      nhit <= nhit + 32'h1;
      loff <= acc.off;
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rdat = prd;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic host(input logic [9:0] a, input logic w, input logic dma, input int n);
    u_host.io_cycle(a, w, dma);
    cmp(nhit, 32'(n));
    $display("test %h done", a);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #100us;
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, bio_pkg::REG_CTRL, 32'h0);
    cmp(rdat, 32'h3);
    apb(1'b0, 12'h00C, 32'h0);
    cmp({rdat[31:1], rerr}, 32'h1);
    apb(1'b0, bio_pkg::REG_STAT, 32'h0);
    cmp(32'(rdat[5:0]), 32'h38);
    host(10'h305, 1'b0, 1'b0, 1);
    cmp(32'(loff), 32'h05);
    cmp({29'h0, acc.chan}, 32'h2);
    cmp({31'h0, acc.is_ctrl}, 32'h1);
    host(10'h31F, 1'b1, 1'b0, 2);
    cmp(32'(loff), 32'h1F);
    cmp({29'h0, acc.chan}, 32'h7);
    cmp({31'h0, acc.is_ctrl}, 32'h0);
    host(10'h2FF, 1'b0, 1'b0, 2);
    host(10'h320, 1'b0, 1'b0, 2);
    host(10'h300, 1'b0, 1'b1, 2);
    apb(1'b0, bio_pkg::REG_HITS, 32'h0);
    cmp(rdat, 32'h2);
    apb(1'b1, bio_pkg::REG_CTRL, 32'h2);
    host(10'h300, 1'b0, 1'b0, 2);
    apb(1'b1, bio_pkg::REG_CTRL, 32'h3);
    bon <= 5'h1F;
    host(10'h010, 1'b0, 1'b0, 2);
    bon <= 5'h17;
    host(10'h11A, 1'b0, 1'b0, 3);
    cirq <= 1'b1;
    repeat (4) @(posedge clk);
    cmp(32'(irq), 32'h20);
    apb(1'b1, bio_pkg::REG_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    cmp(32'(irq), 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
